// File: shared/bac_consts.vh
// Constants for the bridge converter readout block.
// Assumes a 40 MHz system clock and an 18-bit result word.
`ifndef BAC_CONSTS_VH
`define BAC_CONSTS_VH

// System clock and modulator rate, in hertz
`define BAC_CLK_HZ 27'h262_5A00
`define BAC_MOD_HZ 27'h001_2C00
`define BAC_PH_W 27

// Output word rates, samples per second
`define BAC_RATE_SLOW 17'h0_000A
`define BAC_RATE_FAST 17'h0_0050

// Modulator samples per result for each rate
`define BAC_DECIM_SLOW (`BAC_MOD_HZ / `BAC_RATE_SLOW)
`define BAC_DECIM_FAST (`BAC_MOD_HZ / `BAC_RATE_FAST)
`define BAC_DC_W 13

// Filter accumulator width and result width
`define BAC_ACC_W 56
`define BAC_RES_W 18

// Full-scale codes
`define BAC_FS_POS 18'h1_FFFF
`define BAC_FS_NEG 18'h2_0000

// Results discarded after a restart before one is published
`define BAC_SETTLE_SKIP 3'h3

// Standby request: shift clock high for this long, in microseconds
`define BAC_T_STBY_US 20
`define BAC_CLK_MHZ (`BAC_CLK_HZ / 27'h00F_4240)
`define BAC_STBY_CYC (`BAC_T_STBY_US * `BAC_CLK_MHZ)
`define BAC_STBY_W 10

// Bits shifted per result
`define BAC_NBITS 5'h12

// Result buffer
`define BAC_FIFO_DEPTH 16
`define BAC_FIFO_AW 4

`endif

// File: logic/bac_fifo.v
// Result buffer: synchronous FIFO with valid/ready on both sides.
// Assumes one clock for both sides and a power-of-two depth.
`timescale 1ns/10ps
`default_nettype none

module bac_fifo #(
    parameter WIDTH = 18,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire rstn,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;

    // Honest full and empty from the fill count
    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data = mem[rd_q];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule

`default_nettype wire

// File: logic/bac_top.v
// Converter control and serial readout of the bridge converter.
// Assumes the modulator bit arrives on clk; pins are asynchronous.
`timescale 1ns/10ps
`default_nettype none
`include "bac_consts.vh"

// Contract
// - A low rate pin gives 10 results per second, a high one gives 80.
// - Holding the shutdown pin low powers down and resets the converter.
// - Each of the first 18 rising shift-clock edges after ready advances the serial output by one bit.
// - The shift clock doubles as the standby request, judged by its level.
// - The output goes low when a new valid result is ready.
// - The first rising edge after ready starts the result, MSB first.
// - Conversion is continuous with a fourth-order sinc filter at 76.8kHz.
// - At the slow rate the filter notches fall on every multiple of 10Hz.
// - A result is settled only after four full conversion cycles.
// - Control is by pins only; results leave only over the serial pair.
// - Results are 18-bit two's complement, clipped at both full scales.
// - Edges after 18 bits force the output high until the next result.
// - A result not read within one period is overwritten by the next.
// - Shift clock high 20us after ready enters standby; low wakes it.
module bac_top #(
    parameter DECIM_SLOW = `BAC_DECIM_SLOW,
    parameter DECIM_FAST = `BAC_DECIM_FAST
) (
    input wire clk,
    input wire rstn,
    input wire shutdown_n,
    input wire speed,
    input wire sclk,
    input wire mod_bit,
    output reg ready_data_out,
    output reg analog_en
);
    localparam AW = `BAC_ACC_W;
    localparam RW = `BAC_RES_W;
    localparam DW = `BAC_DC_W;
    localparam PW = `BAC_PH_W;
    localparam SW = `BAC_STBY_W;

    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_RDY = 4'h2;
    localparam [3:0] ST_SHF = 4'h4;
    localparam [3:0] ST_END = 4'h8;

    function integer clog2;
        input [AW-1:0] v;
        reg [AW-1:0] t;
        begin
            t = v;
            clog2 = 0;
            while (t != {AW{1'b0}}) begin
                t = t >> 1;
                clog2 = clog2 + 1;
            end
        end
    endfunction

    // Right shift that brings half of the filter span near 2^17
    function integer shift_for;
        input [AW-1:0] half;
        begin
            if (clog2(half) > RW - 1) begin
                shift_for = clog2(half) - (RW - 1);
            end else begin
                shift_for = 0;
            end
        end
    endfunction

    // Clip to the 18-bit full-scale codes
    function [RW-1:0] sat18;
        input signed [AW-1:0] v;
        begin
            if (v > $signed({{(AW-RW+1){1'b0}}, {(RW-1){1'b1}}})) begin
                sat18 = `BAC_FS_POS;
            end else if (v < $signed({{(AW-RW+1){1'b1}},
                    {(RW-1){1'b0}}})) begin
                sat18 = `BAC_FS_NEG;
            end else begin
                sat18 = v[RW-1:0];
            end
        end
    endfunction

    localparam [AW-1:0] DS = DECIM_SLOW;
    localparam [AW-1:0] DF = DECIM_FAST;
    localparam [AW-1:0] HALF_S = (DS * DS * DS * DS) >> 1;
    localparam [AW-1:0] HALF_F = (DF * DF * DF * DF) >> 1;
    localparam integer SH_S = shift_for(HALF_S);
    localparam integer SH_F = shift_for(HALF_F);
    localparam integer DMS_I = DECIM_SLOW - 1;
    localparam integer DMF_I = DECIM_FAST - 1;
    localparam integer STBY_I = `BAC_STBY_CYC;
    localparam [DW-1:0] DMAX_S = DMS_I[DW-1:0];
    localparam [DW-1:0] DMAX_F = DMF_I[DW-1:0];
    localparam [SW-1:0] STBY_CYC = STBY_I[SW-1:0];

    // Pin synchronisers
    reg pd_s1_q;
    reg pd_s2_q;
    reg sclk_s1_q;
    reg sclk_s2_q;
    reg sclk_d3_q;
    reg spd_s1_q;
    reg spd_s2_q;
    reg spd_d3_q;

    always @(posedge clk) begin
        if (!rstn) begin
            pd_s1_q <= 1'b0;
            pd_s2_q <= 1'b0;
            sclk_s1_q <= 1'b0;
            sclk_s2_q <= 1'b0;
            sclk_d3_q <= 1'b0;
            spd_s1_q <= 1'b0;
            spd_s2_q <= 1'b0;
            spd_d3_q <= 1'b0;
        end else begin
            pd_s1_q <= shutdown_n;
            pd_s2_q <= pd_s1_q;
            sclk_s1_q <= sclk;
            sclk_s2_q <= sclk_s1_q;
            sclk_d3_q <= sclk_s2_q;
            spd_s1_q <= speed;
            spd_s2_q <= spd_s1_q;
            spd_d3_q <= spd_s2_q;
        end
    end

    reg standby_q;
    wire clr = !rstn || !pd_s2_q;
    wire sclk_rise = sclk_s2_q && !sclk_d3_q;
    wire restart = clr || standby_q || (spd_s2_q != spd_d3_q);

    // Modulator tick at 76.8 kHz average from a phase accumulator
    reg [PW-1:0] ph_q;
    reg tick_q;
    wire [PW-1:0] ph_sum = ph_q + `BAC_MOD_HZ;
    reg res_vld_q;
    wire fifo_in_ready;
    wire stall = res_vld_q && !fifo_in_ready;

    always @(posedge clk) begin
        if (restart) begin
            ph_q <= {PW{1'b0}};
            tick_q <= 1'b0;
        end else if (stall) begin
            tick_q <= 1'b0;
        end else if (ph_sum >= `BAC_CLK_HZ) begin
            ph_q <= ph_sum - `BAC_CLK_HZ;
            tick_q <= 1'b1;
        end else begin
            ph_q <= ph_sum;
            tick_q <= 1'b0;
        end
    end

    // Sinc4 decimator: four integrators, four combs
    reg [AW-1:0] i1_q;
    reg [AW-1:0] i2_q;
    reg [AW-1:0] i3_q;
    reg [AW-1:0] i4_q;
    reg [AW-1:0] z1_q;
    reg [AW-1:0] z2_q;
    reg [AW-1:0] z3_q;
    reg [AW-1:0] z4_q;
    reg [DW-1:0] dc_q;
    reg [2:0] skip_q;
    reg [RW-1:0] res_q;

    // Combs see the fourth integrator after this tick's update
    wire [AW-1:0] i4_nx = i4_q + i3_q;
    wire [AW-1:0] c1 = i4_nx - z1_q;
    wire [AW-1:0] c2 = c1 - z2_q;
    wire [AW-1:0] c3 = c2 - z3_q;
    wire [AW-1:0] c4 = c3 - z4_q;
    wire [DW-1:0] dmax = spd_s2_q ? DMAX_F : DMAX_S;
    wire [AW-1:0] half = spd_s2_q ? HALF_F : HALF_S;
    wire signed [AW-1:0] centred = $signed(c4 - half);
    wire signed [AW-1:0] scaled = spd_s2_q ? (centred >>> SH_F)
        : (centred >>> SH_S);
    wire dec_end = tick_q && (dc_q == dmax);

    always @(posedge clk) begin
        if (restart) begin
            i1_q <= {AW{1'b0}};
            i2_q <= {AW{1'b0}};
            i3_q <= {AW{1'b0}};
            i4_q <= {AW{1'b0}};
            z1_q <= {AW{1'b0}};
            z2_q <= {AW{1'b0}};
            z3_q <= {AW{1'b0}};
            z4_q <= {AW{1'b0}};
            dc_q <= {DW{1'b0}};
            skip_q <= `BAC_SETTLE_SKIP;
            res_vld_q <= 1'b0;
            res_q <= {RW{1'b0}};
        end else begin
            if (res_vld_q && fifo_in_ready) begin
                res_vld_q <= 1'b0;
            end
            if (tick_q) begin
                i1_q <= i1_q + {{(AW-1){1'b0}}, mod_bit};
                i2_q <= i2_q + i1_q;
                i3_q <= i3_q + i2_q;
                i4_q <= i4_nx;
            end
            if (dec_end) begin
                dc_q <= {DW{1'b0}};
                z1_q <= i4_nx;
                z2_q <= c1;
                z3_q <= c2;
                z4_q <= c3;
                if (skip_q != 3'h0) begin
                    skip_q <= skip_q - 3'h1;
                end else begin
                    res_q <= sat18(scaled);
                    res_vld_q <= 1'b1;
                end
            end else if (tick_q) begin
                dc_q <= dc_q + {{(DW-1){1'b0}}, 1'b1};
            end
        end
    end

    // Result buffer between filter and readout
    wire fifo_out_valid;
    wire [RW-1:0] fifo_out_data;
    wire fifo_pop_ok = !standby_q;

    bac_fifo #(
        .WIDTH(RW),
        .DEPTH(`BAC_FIFO_DEPTH),
        .AW(`BAC_FIFO_AW)
    ) i_bac_fifo (
        .clk(clk),
        .rstn(!clr),
        .in_valid(res_vld_q),
        .in_ready(fifo_in_ready),
        .in_data(res_q),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop_ok),
        .out_data(fifo_out_data)
    );

    wire load = fifo_out_valid && fifo_pop_ok;

    // Serial readout and standby
    reg [3:0] st_q;
    reg [RW-1:0] sh_q;
    reg [4:0] bit_q;
    reg [SW-1:0] hi_q;

    always @(posedge clk) begin
        if (clr) begin
            st_q <= ST_IDLE;
            sh_q <= {RW{1'b0}};
            bit_q <= 5'h0;
            hi_q <= {SW{1'b0}};
            standby_q <= 1'b0;
            ready_data_out <= 1'b1;
            analog_en <= 1'b0;
        end else begin
            analog_en <= !standby_q;
            if (!sclk_s2_q) begin
                hi_q <= {SW{1'b0}};
                standby_q <= 1'b0;
            end else if (st_q != ST_IDLE && hi_q != STBY_CYC) begin
                hi_q <= hi_q + {{(SW-1){1'b0}}, 1'b1};
            end
            if (standby_q) begin
                st_q <= ST_IDLE;
                ready_data_out <= 1'b1;
            end else if (hi_q == STBY_CYC && sclk_s2_q) begin
                standby_q <= 1'b1;
                st_q <= ST_IDLE;
                ready_data_out <= 1'b1;
            end else if (load) begin
                sh_q <= fifo_out_data;
                bit_q <= 5'h0;
                st_q <= ST_RDY;
                ready_data_out <= 1'b0;
            end else if (sclk_rise) begin
                case (st_q)
                    ST_RDY: begin
                        ready_data_out <= sh_q[RW-1];
                        sh_q <= {sh_q[RW-2:0], 1'b0};
                        bit_q <= 5'h1;
                        st_q <= ST_SHF;
                    end
                    ST_SHF: begin
                        if (bit_q == `BAC_NBITS) begin
                            ready_data_out <= 1'b1;
                            st_q <= ST_END;
                        end else begin
                            ready_data_out <= sh_q[RW-1];
                            sh_q <= {sh_q[RW-2:0], 1'b0};
                            bit_q <= bit_q + 5'h1;
                        end
                    end
                    ST_END: begin
                        ready_data_out <= 1'b1;
                    end
                    default: begin
                        ready_data_out <= 1'b1;
                        st_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

`default_nettype wire

// File: testbench/bac_top_sva.sv
// Port checker for the converter readout block.
// Assumes the shared constants header is on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "bac_consts.vh"
module bac_chk (
    input wire logic clk,
    input wire logic rstn,
    input wire logic shutdown_n,
    input wire logic speed,
    input wire logic sclk,
    input wire logic mod_bit,
    input wire logic ready_data_out,
    input wire logic analog_en
);
    logic [10:0] hi_q;
    logic [3:0] sd_q;
    logic [4:0] rc_q;
    logic [3:0] age_q;
    logic sclk_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // High time, powered time, rises since the last quiet gap
    always @(posedge clk) begin
        sclk_q <= sclk;
        if (!rstn) begin
            hi_q <= 11'h000;
            sd_q <= 4'h0;
            rc_q <= 5'h00;
            age_q <= 4'h0;
        end else begin
            hi_q <= !sclk ? 11'h000 : hi_q + {10'h000, hi_q != 11'h7FF};
            sd_q <= !shutdown_n ? 4'h0 : sd_q + {3'h0, sd_q != 4'hF};
            if (sclk && !sclk_q) begin
                rc_q <= rc_q + {4'h0, rc_q != 5'h1F};
                age_q <= 4'h0;
            end else begin
                age_q <= age_q + {3'h0, age_q != 4'hF};
                if (age_q == 4'hF)
                    rc_q <= 5'h00;
            end
        end
    end
    rst_out_idle_a: assert property (disable iff (1'b0) !rstn |=>
        ready_data_out && !analog_en) else $error("outputs active in reset");
    shdn_off_a: assert property ((!shutdown_n) [*4] |=>
        !analog_en && ready_data_out) else $error("shutdown ignored");
    shdn_wake_a: assert property ((shutdown_n && !sclk) [*8] |->
        analog_en) else $error("converter not powered");
    quiet_hold_a: assert property (
        (!sclk && shutdown_n && $stable(speed)) [*6] |->
        !$rose(ready_data_out)) else $error("output rose without an edge");
    stby_enter_a: assert property (
        $fell(analog_en) && sd_q > 4'h8 |-> hi_q >= `BAC_STBY_CYC)
        else $error("standby without long high");
    stby_hold_a: assert property (
        hi_q > `BAC_STBY_CYC + 20 && !analog_en |=>
        !analog_en && ready_data_out) else $error("standby left early");
    stby_wake_a: assert property (
        !analog_en && $fell(sclk) && sd_q > 4'h8 |-> ##[1:8] analog_en)
        else $error("no wake from standby");
    read_end_a: assert property (rc_q > 5'h12 && age_q > 4'h4 |->
        ready_data_out) else $error("output low after the last bit");
endmodule
bind bac_top bac_chk i_bac_chk (.clk(clk), .rstn(rstn),
    .shutdown_n(shutdown_n), .speed(speed), .sclk(sclk), .mod_bit(mod_bit),
    .ready_data_out(ready_data_out), .analog_en(analog_en));
`default_nettype wire

// File: testbench/bac_host.sv
// Host model: clocks results out over the shift clock and data line.
// Assumes each new bit settles within four clk of a shift edge.
`timescale 1ns/10ps
`default_nettype none
module bac_host (
    input wire logic clk,
    input wire logic go,
    input wire logic [4:0] n_edges,
    input wire logic hold_hi,
    input wire logic ready_data_out,
    output logic sclk,
    output logic [17:0] word,
    output logic busy
);
    initial begin
        sclk = 1'b0;
        busy = 1'b0;
        word = 18'h0_0000;
        forever begin
            @(posedge clk);
            if (go && !hold_hi) begin
                busy <= 1'b1;
                // At most 24 edges, well within one period
                for (int i = 0; i < n_edges; i++) begin
                    sclk <= 1'b1;
                    repeat (4) @(posedge clk);
                    sclk <= 1'b0;
                    repeat (4) @(posedge clk);
                    if (i < 18)
                        word <= {word[16:0], ready_data_out};
                end
                busy <= 1'b0;
            end else
                sclk <= hold_hi;
        end
    end
endmodule
`default_nettype wire

// File: testbench/bac_top_bench.sv
// Testbench for the readout block with a host model on the serial pair.
// Assumes the checker binds itself; filter periods are shortened.
`timescale 1ns/10ps
`default_nettype none
`include "bac_consts.vh"
module bac_top_bench;
    localparam int DS = 8;
    localparam int DF = 4;
    localparam int PF = DF * `BAC_CLK_HZ / `BAC_MOD_HZ;
    localparam int PS = DS * `BAC_CLK_HZ / `BAC_MOD_HZ;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic shutdown_n = 1'b1;
    logic speed = 1'b1;
    logic mod_bit = 1'b1;
    logic go = 1'b0;
    logic hold_hi = 1'b0;
    logic [4:0] n_edges = 5'h18;
    logic sclk, ready_data_out, analog_en, busy;
    logic [17:0] word, ref_word;
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    int t_fall, t_go, t0;
    always #12.5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    bac_top #(.DECIM_SLOW(DS), .DECIM_FAST(DF)) i_bac_top (.clk(clk),
        .rstn(rstn), .shutdown_n(shutdown_n), .speed(speed), .sclk(sclk),
        .mod_bit(mod_bit), .ready_data_out(ready_data_out),
        .analog_en(analog_en));
    bac_host i_bac_host (.clk(clk), .go(go), .n_edges(n_edges),
        .hold_hi(hold_hi), .ready_data_out(ready_data_out), .sclk(sclk),
        .word(word), .busy(busy));
    task automatic complete_run;
        if (err_total == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %0t: got %b not %b", $time, got, exp);
        end
    endtask
    task automatic chk_win(input int v, input int lo, input int hi);
        total_checks++;
        if (v < lo || v > hi) begin
            err_total++;
            $display("unexpected %0t: span %0d not in %0d..%0d", $time, v,
                lo, hi);
        end
    endtask
    task automatic wait_fall(input int lim);
        int ts;
        ts = cyc;
        @(posedge clk);
        while (ready_data_out !== 1'b0 && cyc - ts < lim)
            @(posedge clk);
        t_fall = cyc;
    endtask
    task automatic read_word(input logic [4:0] n);
        n_edges <= n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        while (busy === 1'b1)
            @(posedge clk);
    endtask
    task automatic t_reset;
        repeat (6) @(posedge clk);
        chk_bit(ready_data_out, 1'b1);
        chk_bit(analog_en, 1'b0);
        rstn <= 1'b1;
        t_go = cyc;
        repeat (6) @(posedge clk);
        chk_bit(analog_en, 1'b1);
    endtask
    task automatic t_fast;
        wait_fall(5 * PF);
        chk_win(t_fall - t_go, 4 * PF - 20, 4 * PF + 40);
        read_word(5'h18);
        chk_bit(ready_data_out, 1'b1);
        chk_bit(word[17], 1'b0);
        chk_bit(word != 18'h0_0000, 1'b1);
        ref_word = word;
        t0 = t_fall;
        wait_fall(2 * PF);
        chk_win(t_fall - t0, PF - 8, PF + 8);
        read_word(5'h18);
        chk_bit(word === ref_word, 1'b1);
    endtask
    task automatic t_overwrite;
        wait_fall(2 * PF);
        read_word(5'h05);
        repeat (PF) @(posedge clk);
        read_word(5'h18);
        chk_bit(word === ref_word, 1'b1);
    endtask
    task automatic t_standby;
        wait_fall(2 * PF);
        chk_bit(ready_data_out, 1'b0);
        hold_hi <= 1'b1;
        repeat (700) @(posedge clk);
        chk_bit(analog_en, 1'b1);
        repeat (200) @(posedge clk);
        chk_bit(analog_en, 1'b0);
        chk_bit(ready_data_out, 1'b1);
        hold_hi <= 1'b0;
        t_go = cyc;
        repeat (10) @(posedge clk);
        chk_bit(analog_en, 1'b1);
        wait_fall(5 * PF);
        chk_win(t_fall - t_go, 4 * PF - 20, 4 * PF + 40);
    endtask
    task automatic t_shutdown;
        read_word(5'h03);
        shutdown_n <= 1'b0;
        // Input step made only across a restart
        mod_bit <= 1'b0;
        repeat (8) @(posedge clk);
        chk_bit(ready_data_out, 1'b1);
        chk_bit(analog_en, 1'b0);
        shutdown_n <= 1'b1;
        t_go = cyc;
        wait_fall(5 * PF);
        chk_win(t_fall - t_go, 4 * PF - 20, 4 * PF + 50);
        read_word(5'h18);
        chk_bit(word[17], 1'b1);
    endtask
    task automatic t_slow;
        speed <= 1'b0;
        t_go = cyc;
        wait_fall(5 * PS);
        chk_win(t_fall - t_go, 4 * PS - 20, 4 * PS + 40);
        t0 = t_fall;
        read_word(5'h18);
        wait_fall(2 * PS);
        chk_win(t_fall - t0, PS - 8, PS + 8);
    endtask
    initial begin
        t_reset;
        t_fast;
        t_overwrite;
        t_standby;
        t_shutdown;
        t_slow;
        complete_run;
    end
    initial begin
        repeat (80000) @(posedge clk);
        err_total++;
        complete_run;
    end
endmodule
`default_nettype wire
